/* src/ddbl_pkg.sv */
package ddbl_pkg;
	localparam int CHAN_W     = 10;
	localparam int GAMMA_N    = 18;
	localparam int COMMON_N   = 2;
	localparam int CHAN_N     = GAMMA_N + COMMON_N;
	localparam int ADDR_W     = 5;
	localparam int WORD_W     = 16;
	localparam int TRIG_BIT   = 15;
	localparam logic [9:0] MID_CODE = 10'h200;
	localparam logic [4:0] FIRST_COMMON = 5'h12;
	localparam logic [4:0] LAST_ADDR    = 5'h13;
endpackage : ddbl_pkg

/* src/ddbl_chan.sv */
`timescale 1ns/100ps
// one channel: storage register and converter register
module ddbl_chan #(
	parameter int W = ddbl_pkg::CHAN_W
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	// controls
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic         xfer,
	input  wire logic         follow,
	// values
	output logic      [W-1:0] store_q,
	output logic      [W-1:0] conv_q
);
	typedef struct packed {
		logic [W-1:0] store;
		logic [W-1:0] conv;
	} ddbl_chan_st_t;
	ddbl_chan_st_t s_q;
	ddbl_chan_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.store = wr_data;
		end
		if (xfer) begin
			s_d.conv = s_d.store;
		end else if (follow && wr_en) begin
			s_d.conv = wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_q.store <= W'(ddbl_pkg::MID_CODE);
			s_q.conv  <= W'(ddbl_pkg::MID_CODE);
		end else begin
			s_q <= s_d;
		end
	end

	assign store_q = s_q.store;
	assign conv_q  = s_q.conv;
endmodule : ddbl_chan

/* src/ddbl_latch.sv */
`timescale 1ns/100ps
module ddbl_latch #(
	parameter int N = ddbl_pkg::CHAN_N,
	parameter int W = ddbl_pkg::CHAN_W
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	// completed word from the serial front end
	input  wire logic                word_valid,
	input  wire logic [4:0]          word_addr,
	input  wire logic [15:0]         word_data,
	// latch control pin
	input  wire logic                latch_load_pin,
	// converter bank
	output logic      [N-1:0][W-1:0] conv_value,
	// storage bank, for read-back
	output logic      [N-1:0][W-1:0] store_value
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic pin;
	} ddbl_st_t;
	ddbl_st_t s_q;
	ddbl_st_t s_d;

	logic [N-1:0] wr_sel;
	logic         trig;
	logic         fall;
	logic         xfer;
	logic [W-1:0] wr_val;
	logic         in_range;
	logic         gamma_wr;
	logic         common_wr;

	////////////////////////////////////////////////////////////////////////
	// address decode, shared by write strobes and checks
	function automatic logic addr_hit(
		input logic [4:0] a,
		input int         k
	);
		return a == 5'(k);
	endfunction : addr_hit

	function automatic logic addr_common(
		input logic [4:0] a
	);
		return a >= ddbl_pkg::FIRST_COMMON && a <= ddbl_pkg::LAST_ADDR;
	endfunction : addr_common

	////////////////////////////////////////////////////////////////////////
	// word_valid marks the last data bit received
	assign trig      = word_valid && word_data[ddbl_pkg::TRIG_BIT];
	assign fall      = s_q.pin && !latch_load_pin;
	assign xfer      = trig || fall;
	assign wr_val    = word_data[W-1:0];
	assign in_range  = word_addr <= ddbl_pkg::LAST_ADDR;
	assign gamma_wr  = word_valid && word_addr < ddbl_pkg::FIRST_COMMON;
	assign common_wr = word_valid && addr_common(word_addr);

	always_comb begin
		s_d     = s_q;
		s_d.pin = latch_load_pin;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			// history tracks the pin: no false edge at release
			s_q.pin <= latch_load_pin;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel instances
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			assign wr_sel[i] = word_valid
				&& addr_hit(word_addr, i);
			ddbl_chan #(.W(W)) u_ch (
				.sys_clk (sys_clk),
				.resetn  (resetn),
				.wr_en   (wr_sel[i]),
				.wr_data (wr_val),
				.xfer    (xfer),
				.follow  (!latch_load_pin),
				.store_q (store_value[i]),
				.conv_q  (conv_value[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// checks
	// converter bank, with reset checks on both banks
	hold_high_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		latch_load_pin && $past(latch_load_pin) && !trig
		|=> $stable(conv_value))
		else $error("outputs moved while latch held high");
	fall_xfer_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		fall && !word_valid
		|=> conv_value == store_value)
		else $error("falling latch did not transfer");
	pin_fall_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		$fell(latch_load_pin)
		|=> conv_value == store_value)
		else $error("latch pin edge did not transfer");
	sw_trig_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		trig
		|=> conv_value == store_value)
		else $error("software trigger did not transfer");
	follow_low_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!latch_load_pin && word_valid && word_addr == 5'h01
		|=> conv_value[1] == $past(wr_val))
		else $error("output did not follow while latch low");
	follow_bank_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!latch_load_pin
		|=> conv_value == store_value)
		else $error("output bank not following storage");
	no_early_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		latch_load_pin && $past(latch_load_pin) && !word_valid
		|=> $stable(conv_value))
		else $error("transfer without complete word");
	reset_mid_a: assert property (@(posedge sys_clk)
		!resetn
		|=> conv_value[0] == W'(ddbl_pkg::MID_CODE)
		&& store_value[N-1] == W'(ddbl_pkg::MID_CODE))
		else $error("reset did not load mid-scale");
	reset_bank_a: assert property (@(posedge sys_clk)
		!resetn
		|=> conv_value == store_value)
		else $error("reset left banks apart");

	// storage bank
	wr_store_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		word_valid && word_addr == 5'h00
		|=> store_value[0] == $past(wr_val))
		else $error("storage write lost");
	common_voltage_channel_sep_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		gamma_wr
		|=> $stable(store_value[N-1:N-2]))
		else $error("common channel disturbed by gamma write");
	gamma_sep_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		common_wr
		|=> $stable(store_value[N-3:0]))
		else $error("gamma channel disturbed by common write");
	range_ign_a: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		word_valid && !in_range
		|=> $stable(store_value))
		else $error("out of range word changed storage");

	////////////////////////////////////////////////////////////////////////
	// per-channel checks
	generate
		for (i = 0; i < N; i++) begin : g_chk
			ch_reset_a: assert property (@(posedge sys_clk)
				!resetn
				|=> conv_value[i] == W'(ddbl_pkg::MID_CODE)
				&& store_value[i] == W'(ddbl_pkg::MID_CODE))
				else $error("channel not mid-scale after reset");
			ch_write_a: assert property (@(posedge sys_clk)
				disable iff (!resetn)
				word_valid && addr_hit(word_addr, i)
				|=> store_value[i] == $past(wr_val))
				else $error("channel storage write lost");
			ch_keep_a: assert property (@(posedge sys_clk)
				disable iff (!resetn)
				!(word_valid && addr_hit(word_addr, i))
				|=> $stable(store_value[i]))
				else $error("channel storage changed without write");
			// converter side
			ch_hold_a: assert property (@(posedge sys_clk)
				disable iff (!resetn)
				latch_load_pin && !trig
				|=> $stable(conv_value[i]))
				else $error("channel output moved while latch high");
			ch_follow_a: assert property (@(posedge sys_clk)
				disable iff (!resetn)
				!latch_load_pin && word_valid && addr_hit(word_addr, i)
				|=> conv_value[i] == $past(wr_val))
				else $error("channel output did not follow write");
			ch_xfer_a: assert property (@(posedge sys_clk)
				disable iff (!resetn)
				xfer
				|=> conv_value[i] == store_value[i])
				else $error("channel missed bank transfer");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// main scenarios
	c_trig: cover property (@(posedge sys_clk) disable iff (!resetn) trig);
	c_fall: cover property (@(posedge sys_clk) disable iff (!resetn) fall);
	c_last: cover property (@(posedge sys_clk) disable iff (!resetn)
		trig && word_addr == 5'h11);
	c_range: cover property (@(posedge sys_clk) disable iff (!resetn)
		word_valid && !in_range);
	c_follow: cover property (@(posedge sys_clk) disable iff (!resetn)
		!latch_load_pin && gamma_wr);
endmodule : ddbl_latch

/* bench/ddbl_master.sv */
`timescale 1ns/100ps
// serial front end: hands over complete words
module ddbl_master (
	// clock
	input  wire logic        sys_clk,
	// completed word towards the block
	output logic             word_valid,
	output logic [4:0]       word_addr,
	output logic [15:0]      word_data
);
	initial begin
		word_valid = 1'b0;
		word_addr = 5'h00;
		word_data = 16'h0000;
	end
	task automatic send(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		word_valid = 1'b1;
		word_addr = a;
		word_data = d;
		@(negedge sys_clk);
		word_valid = 1'b0;
		word_addr = ~a;
		word_data = ~d;
	endtask : send
endmodule : ddbl_master

/* bench/ddbl_latch_tb_top.sv */
`timescale 1ns/100ps
module ddbl_latch_tb_top;
	logic             sys_clk;
	logic             resetn;
	logic             latch_load_pin;
	logic             word_valid;
	logic [4:0]       word_addr;
	logic [15:0]      word_data;
	logic [19:0][9:0] conv_value;
	logic [19:0][9:0] store_value;
	int               err_total;
	int               cmp_count;
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	ddbl_master u_ddbl_master (.sys_clk(sys_clk), .word_valid(word_valid),
		.word_addr(word_addr), .word_data(word_data));
	ddbl_latch u_ddbl_latch (.sys_clk(sys_clk), .resetn(resetn),
		.word_valid(word_valid), .word_addr(word_addr),
		.word_data(word_data), .latch_load_pin(latch_load_pin),
		.conv_value(conv_value), .store_value(store_value));
	task automatic chk(string n, logic [9:0] e, logic [9:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic t_mid;
		for (int i = 0; i < 20; i++) begin
			chk("conv", 10'h200, conv_value[i]);
			chk("store", 10'h200, store_value[i]);
		end
	endtask : t_mid
	task automatic t_hold;
		latch_load_pin = 1'b1;
		u_ddbl_master.send(5'h03, 16'h3FAB);
		chk("store3", 10'h3AB, store_value[3]);
		chk("conv3", 10'h200, conv_value[3]);
	endtask : t_hold
	task automatic t_soft;
		logic [9:0] v;
		for (int i = 0; i < 18; i++) begin
			v = 10'(i * 37);
			u_ddbl_master.send(5'(i), {i == 17, 5'h00, v});
			if (i == 16) chk("conv0", 10'h200, conv_value[0]);
		end
		for (int i = 0; i < 20; i++) begin
			v = i < 18 ? 10'(i * 37) : 10'h200;
			chk("soft", v, conv_value[i]);
		end
	endtask : t_soft
	task automatic t_rewrite;
		logic [9:0] v;
		for (int i = 0; i < 18; i++) begin
			v = 10'(i + 10'h100);
			u_ddbl_master.send(5'(i), {6'h00, v});
		end
		chk("held", 10'h0B9, conv_value[5]);
		u_ddbl_master.send(5'h05, 16'h8105);
		for (int i = 0; i < 18; i++) begin
			v = 10'(i + 10'h100);
			chk("rewrite", v, conv_value[i]);
		end
		u_ddbl_master.send(5'h14, 16'h0123);
		chk("range", 10'h104, store_value[4]);
	endtask : t_rewrite
	task automatic t_rearm;
		resetn = 1'b1;
		u_ddbl_master.send(5'h07, 16'h0321);
		chk("rearm7", 10'h321, conv_value[7]);
		chk("rearm6", 10'h200, conv_value[6]);
	endtask : t_rearm
	task automatic t_fall;
		u_ddbl_master.send(5'h13, 16'h0155);
		chk("conv19", 10'h200, conv_value[19]);
		latch_load_pin = 1'b0;
		@(negedge sys_clk);
		chk("fall", 10'h155, conv_value[19]);
		u_ddbl_master.send(5'h12, 16'h00AA);
		chk("conv18", 10'h0AA, conv_value[18]);
		chk("store19", 10'h155, store_value[19]);
	endtask : t_fall
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		err_total = 0;
		cmp_count = 0;
		resetn = 1'b0;
		latch_load_pin = 1'b1;
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		t_mid();
		t_hold();
		t_soft();
		t_rewrite();
		t_fall();
		resetn = 1'b0;
		@(negedge sys_clk);
		t_mid();
		t_rearm();
		close_out();
	end
	initial begin
		#5000;
		err_total++;
		close_out();
	end
endmodule : ddbl_latch_tb_top
